/* File: core/csr_pkg.sv */
// Purpose: Constants for the core special register block.
// Assumes: 8-bit internal register address space, byte-wide data.
// Notes: Offsets, field positions and reset values live only here.
package csr_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFF_STACK_TOP = 8'h81;
  localparam logic [7:0] OFF_PTR_LOW = 8'h82;
  localparam logic [7:0] OFF_PTR_HIGH = 8'h83;
  localparam logic [7:0] OFF_FLAGS = 8'hD0;
  localparam logic [7:0] OFF_MAIN_ARITH = 8'hE0;
  localparam logic [7:0] OFF_SECOND_OP = 8'hF0;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_STACK_TOP = 8'h07;
  localparam logic [7:0] RST_PTR_LOW = 8'h00;
  localparam logic [7:0] RST_PTR_HIGH = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_MAIN_ARITH = 8'h00;
  localparam logic [7:0] RST_SECOND_OP = 8'h00;

  // ****************************************
  // Flags word field positions
  // ****************************************
  localparam int FLG_CARRY = 7;
  localparam int FLG_HALF = 6;
  localparam int FLG_USER0 = 5;
  localparam int FLG_BANK_HI = 4;
  localparam int FLG_BANK_LO = 3;
  localparam int FLG_WRAP = 2;
  localparam int FLG_USER1 = 1;
  localparam int FLG_PARITY = 0;

  // Bank size in bytes, as a shift of the bank number
  localparam int BANK_SHIFT = 3;

  // ****************************************
  // Operations the execution unit may request
  // ****************************************
  typedef enum logic [3:0] {
    CSR_OP_NONE,
    CSR_OP_ADD,
    CSR_OP_ADDC,
    CSR_OP_SUBB,
    CSR_OP_MUL,
    CSR_OP_DIV,
    CSR_OP_CMP_JNE,
    CSR_OP_DEC_ADJ
  } csr_op_t;

endpackage : csr_pkg

/* File: core/csr_alu.sv */
// Purpose: Arithmetic unit that produces results and flag updates.
// Assumes: Purely combinational; operands come from the registers or from the external operand ports.
// Notes: Divide by zero returns all ones and raises the wrap flag.
module csr_alu
  import csr_pkg::*;
(
  input wire csr_op_t op,           // Requested operation
  input wire logic [7:0] opa,       // First operand
  input wire logic [7:0] opb,       // Second operand
  input wire logic carry_in,        // Carry flag before the operation
  input wire logic half_in,         // Half-carry before the operation
  output logic [7:0] res_a,         // Result for main arithmetic register
  output logic [7:0] res_b,         // Result for second operand register
  output logic wr_a,                // Main register is written
  output logic wr_b,                // Second register is written
  output logic upd_carry,           // Carry flag is updated
  output logic carry_out,           // New carry value
  output logic upd_half,            // Half-carry flag is updated
  output logic half_out,            // New half-carry value
  output logic upd_wrap,            // Wrap flag is updated
  output logic wrap_out             // New wrap value
);

  logic cin;
  logic [4:0] low_sum;
  logic [7:0] low7_sum;
  logic [8:0] full_sum;
  logic [4:0] low_dif;
  logic [7:0] low7_dif;
  logic [8:0] full_dif;
  logic [15:0] product;
  logic [8:0] adj_lo;
  logic [8:0] adj_hi;

  // Adder and subtractor chains, split to expose bit 3 and bit 6 carries
  always_comb begin
    cin = (op == CSR_OP_ADDC || op == CSR_OP_SUBB) ? carry_in : 1'b0;
    low_sum = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
    low7_sum = {1'b0, opa[6:0]} + {1'b0, opb[6:0]} + {7'h00, cin};
    full_sum = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
    low_dif = {1'b0, opa[3:0]} - {1'b0, opb[3:0]} - {4'h0, cin};
    low7_dif = {1'b0, opa[6:0]} - {1'b0, opb[6:0]} - {7'h00, cin};
    full_dif = {1'b0, opa} - {1'b0, opb} - {8'h00, cin};
    product = opa * opb;
  end

  // Decimal adjust in two steps: low digit, then high digit
  always_comb begin
    adj_lo = {1'b0, opa};
    if (half_in || opa[3:0] > 4'h9) begin
      adj_lo = {1'b0, opa} + 9'h006;
    end
    adj_hi = adj_lo;
    if (carry_in || adj_lo[8] || adj_lo[7:4] > 4'h9) begin
      adj_hi = adj_lo + 9'h060;
    end
  end

  // Result and flag selection per operation
  always_comb begin
    res_a = opa;
    res_b = opb;
    wr_a = 1'b0;
    wr_b = 1'b0;
    upd_carry = 1'b0;
    carry_out = carry_in;
    upd_half = 1'b0;
    half_out = half_in;
    upd_wrap = 1'b0;
    wrap_out = 1'b0;
    case (op)
      CSR_OP_ADD, CSR_OP_ADDC: begin
        res_a = full_sum[7:0];
        wr_a = 1'b1;
        upd_carry = 1'b1;
        carry_out = full_sum[8];
        upd_half = 1'b1;
        half_out = low_sum[4];
        upd_wrap = 1'b1;
        wrap_out = full_sum[8] ^ low7_sum[7];
      end
      CSR_OP_SUBB: begin
        res_a = full_dif[7:0];
        wr_a = 1'b1;
        upd_carry = 1'b1;
        carry_out = full_dif[8];
        upd_half = 1'b1;
        half_out = low_dif[4];
        upd_wrap = 1'b1;
        wrap_out = full_dif[8] ^ low7_dif[7];
      end
      CSR_OP_MUL: begin
        res_a = product[7:0];
        res_b = product[15:8];
        wr_a = 1'b1;
        wr_b = 1'b1;
        upd_carry = 1'b1;
        carry_out = 1'b0;
        upd_wrap = 1'b1;
        wrap_out = (product[15:8] != 8'h00);
      end
      CSR_OP_DIV: begin
        upd_carry = 1'b1;
        carry_out = 1'b0;
        upd_wrap = 1'b1;
        wr_a = 1'b1;
        wr_b = 1'b1;
        if (opb == 8'h00) begin
          // Undefined result; a fixed pattern keeps simulation clean
          res_a = 8'hFF;
          res_b = 8'hFF;
          wrap_out = 1'b1;
        end else begin
          res_a = opa / opb;
          res_b = opa % opb;
        end
      end
      CSR_OP_CMP_JNE: begin
        upd_carry = 1'b1;
        carry_out = (opa < opb);
      end
      CSR_OP_DEC_ADJ: begin
        res_a = adj_hi[7:0];
        wr_a = 1'b1;
        upd_carry = 1'b1;
        // Carry only ever sets here, never clears
        carry_out = carry_in | adj_hi[8] | adj_lo[8];
      end
      default: begin
      end
    endcase
  end

endmodule : csr_alu

/* File: core/csr_regs.sv */
// Purpose: Core special registers of a small 8-bit CPU.
// Assumes: One clock, synchronous active-high reset, single bus master.
// Notes: Execution-unit updates win over a software write in the same
//   cycle for the bits they touch; read data lags the strobe by one cycle.
// Function
// - Main arithmetic register at E0, read/write, resets to zero.
// - Second operand register at F0, resets to zero, multiply/divide aid.
// - Stack top pointer at 81 resets to 07, first push lands at 08.
// - Push or call increments pointer first, then writes the byte.
// - Pointer bytes at 82 and 83 form one 16-bit external pointer.
// - Flags word at D0 resets zero; fixed bit layout, parity read-only.
// - Add or subtract sets carry on carry out or borrow out.
// - Multiply and divide always clear the carry flag.
// - Compare-jump sets carry when first operand is below the second.
// - Decimal adjust sets carry when the packed sum passes 99.
// - Two bank bits choose one of four eight-byte register banks.
// - Overflow on add bit 6/7 carry mismatch, on multiply above 255.
//
// Our own choice: the address-and-strobe port.
module csr_regs
  import csr_pkg::*;
(
  input wire logic ref_clk,              // System clock, 200 MHz
  input wire logic srst,                 // Synchronous reset, active high
  input wire logic [7:0] reg_addr,       // Register address
  input wire logic [7:0] reg_wdata,      // Register write data
  input wire logic reg_wr,               // Write strobe
  input wire logic reg_rd,               // Read strobe
  output logic [7:0] reg_rdata,          // Read data, one cycle later
  input wire logic bit_wr,               // Single-bit write strobe
  input wire logic [7:0] bit_addr,       // Bit address, register plus bit
  input wire logic bit_val,              // Bit value to write
  input wire csr_op_t alu_op,            // Arithmetic operation, one cycle
  input wire logic [7:0] alu_opa_ext,    // First operand for compare-jump
  input wire logic alu_use_ext,          // Compare uses external operands
  input wire logic [7:0] alu_opb_ext,    // Second operand when external
  input wire logic push_req,             // Push or call byte request
  input wire logic [7:0] push_data,      // Byte to push
  output logic [7:0] stack_wr_addr,      // Scratch-pad write address
  output logic [7:0] stack_wr_data,      // Scratch-pad write data
  output logic stack_wr_en,              // Scratch-pad write strobe
  input wire logic pop_req,              // Pop or return: pointer decrement
  output logic [15:0] ext_ptr_16,        // Combined external pointer
  output logic [7:0] bank_base,          // Base address of working bank
  output logic [7:0] main_arith_out,     // Main register value
  output logic [7:0] flags_out           // Flags word value
);

  // ****************************************
  // State
  // ****************************************
  logic [7:0] main_arith_reg;
  logic [7:0] second_operand_reg;
  logic [7:0] stack_top_pointer;
  logic [7:0] ext_ptr_low;
  logic [7:0] ext_ptr_high;
  logic carry_flag;
  logic half_carry_flag;
  logic user_flag_zero;
  logic bank_sel_hi;
  logic bank_sel_lo;
  logic signed_wrap_flag;
  logic user_flag_one;
  logic parity_bit;
  logic [7:0] flags_word;
  logic push_pending;
  logic [7:0] push_hold;

  // ALU connections
  logic [7:0] res_a;
  logic [7:0] res_b;
  logic wr_a;
  logic wr_b;
  logic upd_carry;
  logic carry_out;
  logic upd_half;
  logic half_out;
  logic upd_wrap;
  logic wrap_out;
  logic [7:0] opa_sel;
  logic [7:0] opb_sel;

  // Write decode and next values
  logic [7:0] next_main_arith;
  logic [7:0] next_second_op;
  logic [7:0] next_flags;

  // Bit-write helper: true when the bit address falls in the register
  function automatic logic bit_hit(input logic [7:0] ba,
                                   input logic [7:0] base);
    bit_hit = (ba[7:3] == base[7:3]);
  endfunction : bit_hit

  // Apply a byte write, or else a bit write, to a stored value
  function automatic logic [7:0] apply_wr(input logic [7:0] cur,
                                          input logic [7:0] base,
                                          input logic [7:0] ra,
                                          input logic we,
                                          input logic [7:0] wd,
                                          input logic bwe,
                                          input logic [7:0] ba,
                                          input logic bv);
    logic [7:0] v;
    v = cur;
    if (we && ra == base) begin
      v = wd;
    end else if (bwe && bit_hit(ba, base)) begin
      v[ba[2:0]] = bv;
    end
    apply_wr = v;
  endfunction : apply_wr

  // ****************************************
  // Arithmetic unit
  // ****************************************
  // Compare may take an immediate or memory operand instead of the registers
  assign opa_sel = alu_use_ext ? alu_opa_ext : main_arith_reg;
  assign opb_sel = alu_use_ext ? alu_opb_ext : second_operand_reg;

  csr_alu u_alu (
    .op(alu_op),
    .opa(opa_sel),
    .opb(opb_sel),
    .carry_in(carry_flag),
    .half_in(half_carry_flag),
    .res_a(res_a),
    .res_b(res_b),
    .wr_a(wr_a),
    .wr_b(wr_b),
    .upd_carry(upd_carry),
    .carry_out(carry_out),
    .upd_half(upd_half),
    .half_out(half_out),
    .upd_wrap(upd_wrap),
    .wrap_out(wrap_out)
  );

  // ****************************************
  // Flags word assembly
  // ****************************************
  // Parity is pure logic so it never lags the main register
  assign parity_bit = ^main_arith_reg;

  always_comb begin
    flags_word = 8'h00;
    flags_word[FLG_CARRY] = carry_flag;
    flags_word[FLG_HALF] = half_carry_flag;
    flags_word[FLG_USER0] = user_flag_zero;
    flags_word[FLG_BANK_HI] = bank_sel_hi;
    flags_word[FLG_BANK_LO] = bank_sel_lo;
    flags_word[FLG_WRAP] = signed_wrap_flag;
    flags_word[FLG_USER1] = user_flag_one;
    flags_word[FLG_PARITY] = parity_bit;
  end

  // Software-side next values, before arithmetic overrides
  always_comb begin
    next_main_arith = apply_wr(main_arith_reg, OFF_MAIN_ARITH, reg_addr,
                               reg_wr, reg_wdata, bit_wr, bit_addr, bit_val);
    next_second_op = apply_wr(second_operand_reg, OFF_SECOND_OP, reg_addr,
                              reg_wr, reg_wdata, bit_wr, bit_addr, bit_val);
    next_flags = apply_wr(flags_word, OFF_FLAGS, reg_addr,
                          reg_wr, reg_wdata, bit_wr, bit_addr, bit_val);
  end

  // ****************************************
  // Main and second operand registers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      main_arith_reg <= RST_MAIN_ARITH;
    end else if (wr_a) begin
      main_arith_reg <= res_a;
    end else begin
      main_arith_reg <= next_main_arith;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      second_operand_reg <= RST_SECOND_OP;
    end else if (wr_b) begin
      second_operand_reg <= res_b;
    end else begin
      second_operand_reg <= next_second_op;
    end
  end

  // ****************************************
  // Flags word; hardware update beats software on the same bit
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      {carry_flag, half_carry_flag, user_flag_zero, bank_sel_hi,
       bank_sel_lo, signed_wrap_flag, user_flag_one} <= RST_FLAGS[7:1];
    end else begin
      // Parity bit of next_flags is simply dropped: writes ignored
      user_flag_zero <= next_flags[FLG_USER0];
      bank_sel_hi <= next_flags[FLG_BANK_HI];
      bank_sel_lo <= next_flags[FLG_BANK_LO];
      user_flag_one <= next_flags[FLG_USER1];
      carry_flag <= upd_carry ? carry_out : next_flags[FLG_CARRY];
      half_carry_flag <= upd_half ? half_out : next_flags[FLG_HALF];
      signed_wrap_flag <= upd_wrap ? wrap_out : next_flags[FLG_WRAP];
    end
  end

  // ****************************************
  // Stack pointer and push sequencing
  // ****************************************
  // Push takes two cycles: bump the pointer, then store at the new value
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stack_top_pointer <= RST_STACK_TOP;
    end else if (push_req) begin
      stack_top_pointer <= stack_top_pointer + 8'h01;
    end else if (pop_req) begin
      stack_top_pointer <= stack_top_pointer - 8'h01;
    end else if (reg_wr && reg_addr == OFF_STACK_TOP) begin
      stack_top_pointer <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      push_pending <= 1'b0;
      push_hold <= 8'h00;
    end else begin
      push_pending <= push_req;
      if (push_req) begin
        push_hold <= push_data;
      end
    end
  end

  // Write strobe follows the increment by one cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stack_wr_en <= 1'b0;
      stack_wr_addr <= 8'h00;
      stack_wr_data <= 8'h00;
    end else begin
      stack_wr_en <= push_pending;
      stack_wr_addr <= stack_top_pointer;
      stack_wr_data <= push_hold;
    end
  end

  // ****************************************
  // External pointer bytes
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ext_ptr_low <= RST_PTR_LOW;
      ext_ptr_high <= RST_PTR_HIGH;
    end else if (reg_wr && reg_addr == OFF_PTR_LOW) begin
      ext_ptr_low <= reg_wdata;
    end else if (reg_wr && reg_addr == OFF_PTR_HIGH) begin
      ext_ptr_high <= reg_wdata;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign ext_ptr_16 = {ext_ptr_high, ext_ptr_low};
  // Bank n starts at n times eight
  assign bank_base = {6'h00, bank_sel_hi, bank_sel_lo}
                     << BANK_SHIFT;

  // Two bank bits shifted by the bank size must still fit one byte
  if (BANK_SHIFT > 6) begin : g_bank_size_check
    $error("Bank size does not fit the register address byte");
  end
  assign main_arith_out = main_arith_reg;
  assign flags_out = flags_word;

  // Read port; unmapped addresses answer zero
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == OFF_MAIN_ARITH) begin
        reg_rdata <= main_arith_reg;
      end else if (reg_addr == OFF_SECOND_OP) begin
        reg_rdata <= second_operand_reg;
      end else if (reg_addr == OFF_STACK_TOP) begin
        reg_rdata <= stack_top_pointer;
      end else if (reg_addr == OFF_PTR_LOW) begin
        reg_rdata <= ext_ptr_low;
      end else if (reg_addr == OFF_PTR_HIGH) begin
        reg_rdata <= ext_ptr_high;
      end else if (reg_addr == OFF_FLAGS) begin
        reg_rdata <= flags_word;
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : csr_regs

/* File: sim/csr_regs_monitor.sv */
// Purpose: Port-level checks for the core special register block.
// Assumes: One clock, synchronous active-high reset, no bit write
//   beside a byte write.
// Notes: Stack pointer is internal, so push checks use write addresses.
module csr_regs_monitor
  import csr_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic srst, // Reset
  input wire logic [7:0] reg_addr, // Address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire csr_op_t alu_op, // Operation
  input wire logic [7:0] alu_opa_ext, // First operand
  input wire logic alu_use_ext, // External operands
  input wire logic [7:0] alu_opb_ext, // Second operand
  input wire logic push_req, // Push
  input wire logic [7:0] push_data, // Push byte
  input wire logic [7:0] stack_wr_addr, // Stack address
  input wire logic [7:0] stack_wr_data, // Stack data
  input wire logic stack_wr_en, // Stack strobe
  input wire logic [15:0] ext_ptr_16, // Pointer
  input wire logic [7:0] bank_base, // Bank base
  input wire logic [7:0] main_arith_out, // Main register
  input wire logic [7:0] flags_out // Flags word
);
  // ****************
  // Clocking and push steps
  // ****************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence push_s;
    push_req;
  endsequence
  // Two strobes in a row mean two pushes in a row
  sequence two_wr_s;
    stack_wr_en ##1 stack_wr_en;
  endsequence

  // ****************
  // Assertions
  // ****************
  a_reset_values: assert property (
    $fell(srst) |-> main_arith_out == RST_MAIN_ARITH
      && flags_out == RST_FLAGS && ext_ptr_16 == 16'h0000)
    else $error("Register left reset with a nonzero value");
  a_main_write: assert property (
    reg_wr && reg_addr == OFF_MAIN_ARITH && alu_op == CSR_OP_NONE
      |=> main_arith_out == $past(reg_wdata))
    else $error("Main register missed a write");
  a_main_read: assert property (
    reg_rd && reg_addr == OFF_MAIN_ARITH |=> reg_rdata == $past(main_arith_out))
    else $error("Main register read returned another value");
  a_ptr_bytes: assert property (
    reg_wr && reg_addr == OFF_PTR_HIGH |=>
      ext_ptr_16 == {$past(reg_wdata), $past(ext_ptr_16[7:0])})
    else $error("Pointer bytes not joined as written");
  a_flags_write: assert property (
    reg_wr && reg_addr == OFF_FLAGS && alu_op == CSR_OP_NONE
      |=> flags_out[7:1] == $past(reg_wdata[7:1]))
    else $error("Flags word missed a write");
  a_parity_track: assert property (
    flags_out[FLG_PARITY] == ^main_arith_out)
    else $error("Parity bit does not follow main register");
  a_bank_base: assert property (
    bank_base == {3'b000, flags_out[FLG_BANK_HI:FLG_BANK_LO], 3'b000})
    else $error("Bank base does not follow bank bits");
  a_muldiv_carry: assert property (
    alu_op == CSR_OP_MUL || alu_op == CSR_OP_DIV |=> !flags_out[FLG_CARRY])
    else $error("Carry left set after multiply or divide");
  a_cmp_carry: assert property (
    alu_op == CSR_OP_CMP_JNE && alu_use_ext |=>
      flags_out[FLG_CARRY] == ($past(alu_opa_ext) < $past(alu_opb_ext)))
    else $error("Compare carry wrong");
  a_push_data: assert property (
    push_s |-> ##2 stack_wr_en && stack_wr_data == $past(push_data, 2))
    else $error("Pushed byte not written two cycles on");
  a_push_order: assert property (
    two_wr_s |-> stack_wr_addr == $past(stack_wr_addr) + 8'h01)
    else $error("Back-to-back pushes not one place apart");
endmodule : csr_regs_monitor

bind csr_regs csr_regs_monitor csr_regs_monitor_i (
  .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .alu_op(alu_op), .alu_opa_ext(alu_opa_ext),
  .alu_use_ext(alu_use_ext), .alu_opb_ext(alu_opb_ext),
  .push_req(push_req), .push_data(push_data),
  .stack_wr_addr(stack_wr_addr), .stack_wr_data(stack_wr_data),
  .stack_wr_en(stack_wr_en), .ext_ptr_16(ext_ptr_16),
  .bank_base(bank_base), .main_arith_out(main_arith_out),
  .flags_out(flags_out)
);

/* File: sim/tb.sv */
// Purpose: Self-checking bench for the core special register block.
// Assumes: Bench drives every port itself; reads answer one cycle on.
// Notes: One bit write into the main register; otherwise bit port idle.
module tb
  import csr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Signals and notes
  // ****************
  logic ref_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic bit_wr = 1'b0, bit_val = 1'b0, alu_use_ext = 1'b0;
  logic [7:0] bit_addr = 8'h00, alu_opa_ext = 8'h00, alu_opb_ext = 8'h00;
  csr_op_t alu_op = CSR_OP_NONE;
  logic push_req = 1'b0, pop_req = 1'b0, stack_wr_en, pend = 1'b0;
  logic [7:0] push_data = 8'h00, stack_wr_addr, stack_wr_data;
  logic [7:0] bank_base, main_arith_out, flags_out, vals[4];
  logic [15:0] ext_ptr_16, sq[$];
  logic [7:0] rq[$];
  logic [63:0] c;
  int fails = 0, checks = 0, cyc = 0, seed = 79;
  logic [7:0] offs[4] = '{OFF_MAIN_ARITH, OFF_SECOND_OP, OFF_PTR_LOW,
                          OFF_PTR_HIGH};
  // main, second, flags, op, main, second, flags, flag mask
  logic [63:0] alu_cases[11] = '{
    64'hFF01_0001_0001_C0FF, 64'h7F01_0001_8001_45FF,
    64'h0101_8002_0301_00FF, 64'h0001_0003_FF01_C0FF,
    64'h1020_8004_0002_04FF, 64'h0305_8404_0F00_00FF,
    64'h0702_8005_0301_00FF, 64'h0305_0006_0305_80FF,
    64'h0503_8006_0503_00FF, 64'h9A01_0007_0001_8080,
    64'h0700_8005_FFFF_04FF};

  csr_regs csr_regs_i (
    .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bit_wr(bit_wr), .bit_addr(bit_addr),
    .bit_val(bit_val), .alu_op(alu_op), .alu_opa_ext(alu_opa_ext),
    .alu_use_ext(alu_use_ext), .alu_opb_ext(alu_opb_ext),
    .push_req(push_req), .push_data(push_data),
    .stack_wr_addr(stack_wr_addr), .stack_wr_data(stack_wr_data),
    .stack_wr_en(stack_wr_en), .pop_req(pop_req),
    .ext_ptr_16(ext_ptr_16), .bank_base(bank_base),
    .main_arith_out(main_arith_out), .flags_out(flags_out));

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  // ****************
  // Tasks
  // ****************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Every signal assigned once per call, so back-to-back calls are safe
  task automatic drive(input logic w, r, input logic [7:0] a, d,
                       input csr_op_t op, input logic pu, po);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    push_data <= d;
    alu_op <= op;
    push_req <= pu;
    pop_req <= po;
    @(posedge ref_clk);
  endtask : drive

  task automatic wr(input logic [7:0] a, d);
    drive(1'b1, 1'b0, a, d, CSR_OP_NONE, 1'b0, 1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] a, e);
    rq.push_back(e);
    drive(1'b0, 1'b1, a, 8'h00, CSR_OP_NONE, 1'b0, 1'b0);
  endtask : rd

  task automatic idle;
    drive(1'b0, 1'b0, 8'h00, 8'h00, CSR_OP_NONE, 1'b0, 1'b0);
  endtask : idle

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // Results arrive in request order, so the oldest note is the match
  always @(posedge ref_clk) begin
    if (pend) check({8'h00, reg_rdata}, {8'h00, rq.pop_front()});
    // Strobe is unknown until the first reset edge has landed
    if (!srst && stack_wr_en !== 1'b0) check({stack_wr_addr, stack_wr_data},
                                    sq.pop_front());
    pend <= reg_rd;
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fails++;
      give_verdict();
    end
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    rd(OFF_MAIN_ARITH, RST_MAIN_ARITH);
    rd(OFF_SECOND_OP, RST_SECOND_OP);
    rd(OFF_STACK_TOP, RST_STACK_TOP);
    rd(OFF_PTR_LOW, RST_PTR_LOW);
    rd(OFF_PTR_HIGH, RST_PTR_HIGH);
    rd(OFF_FLAGS, RST_FLAGS);
    wr(8'h84, 8'h5A);
    rd(8'h84, 8'h00);
    $display("Test reset values done");
    // Push wins over a pop in the same cycle
    sq.push_back({8'h08, 8'hAA});
    sq.push_back({8'h09, 8'h3C});
    drive(1'b0, 1'b0, 8'h00, 8'hAA, CSR_OP_NONE, 1'b1, 1'b0);
    drive(1'b0, 1'b0, 8'h00, 8'h3C, CSR_OP_NONE, 1'b1, 1'b1);
    idle;
    idle;
    rd(OFF_STACK_TOP, 8'h09);
    drive(1'b0, 1'b0, 8'h00, 8'h00, CSR_OP_NONE, 1'b0, 1'b1);
    rd(OFF_STACK_TOP, 8'h08);
    srst <= 1'b1;
    idle;
    srst <= 1'b0;
    rd(OFF_STACK_TOP, RST_STACK_TOP);
    $display("Test stack done");
    foreach (offs[i]) begin
      vals[i] = 8'($random(seed));
      wr(offs[i], vals[i]);
      rd(offs[i], vals[i]);
    end
    idle;
    check(ext_ptr_16, {vals[3], vals[2]});
    wr(OFF_FLAGS, 8'hFF);
    rd(OFF_FLAGS, {7'h7F, ^vals[0]});
    for (int b = 0; b < 4; b++) begin
      wr(OFF_FLAGS, 8'(b << 3));
      idle;
      check({8'h00, bank_base}, 16'(b * 8));
    end
    // Bit write sets the top bit of the main register only
    bit_addr <= OFF_MAIN_ARITH | 8'h07;
    bit_val <= 1'b1;
    bit_wr <= 1'b1;
    idle;
    bit_wr <= 1'b0;
    rd(OFF_MAIN_ARITH, vals[0] | 8'h80);
    $display("Test registers done");
    foreach (alu_cases[i]) begin
      c = alu_cases[i];
      alu_opa_ext <= c[63:56];
      alu_opb_ext <= c[55:48];
      alu_use_ext <= (c[35:32] == 4'h6);
      wr(OFF_MAIN_ARITH, c[63:56]);
      wr(OFF_SECOND_OP, c[55:48]);
      wr(OFF_FLAGS, c[47:40]);
      drive(1'b0, 1'b0, 8'h00, 8'h00, csr_op_t'(c[35:32]), 1'b0, 1'b0);
      rd(OFF_MAIN_ARITH, c[31:24]);
      rd(OFF_SECOND_OP, c[23:16]);
      check({8'h00, flags_out & c[7:0]}, {8'h00, c[15:8] & c[7:0]});
    end
    idle;
    idle;
    check(16'(sq.size()), 16'h0000);
    $display("Test arithmetic flags done");
    give_verdict();
  end
endmodule : tb
